// ---- rtl/pjm_top.sv ----
// Purpose: pin function select and direction for low port H and port J
// Assumes: AXI4-Lite slave, 32-bit data, REF_CLK at 10 MHz
// Notes:   register reset only on power-on or hardware standby
`timescale 1ns/1ps
module pjm_top
  import pjm_pkg::*;
(
  // clock and reset
  input  wire logic        REF_CLK,
  input  wire logic        RST_B,
  // reset sources and device mode
  input  wire logic        HW_STANDBY,
  input  wire logic [1:0]  OP_MODE,
  // axi4-lite write address
  input  wire logic [7:0]  AWADDR,
  input  wire logic        AWVALID,
  output logic             AWREADY,
  // axi4-lite write data
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  input  wire logic        WVALID,
  output logic             WREADY,
  // axi4-lite write response
  output logic [1:0]       BRESP,
  output logic             BVALID,
  input  wire logic        BREADY,
  // axi4-lite read address
  input  wire logic [7:0]  ARADDR,
  input  wire logic        ARVALID,
  output logic             ARREADY,
  // axi4-lite read data
  output logic [31:0]      RDATA,
  output logic [1:0]       RRESP,
  output logic             RVALID,
  input  wire logic        RREADY,
  // port H low pins
  input  wire logic [5:0]  H_GPIO_DIR,
  input  wire logic [5:0]  H_GPIO_OUT,
  input  wire logic [5:0]  EXT_DATA_OE,
  input  wire logic [5:0]  EXT_DATA_OUT,
  output logic [5:0]       H_IS_BUS,
  output logic [5:0]       H_PIN_OUT,
  output logic [5:0]       H_PIN_OE,
  // port J pins
  input  wire logic [15:0] J_GPIO_OUT,
  input  wire logic [15:0] J_TIMER_OUT,
  output logic [15:0]      J_TIMER_SEL,
  output logic [15:0]      J_PIN_OUT,
  output logic [15:0]      J_PIN_OE
);
  // registers
  logic [5:0]  hport_mode;
  logic [15:0] port_j_direction;
  logic [15:0] port_j_function_high;
  logic [15:0] port_j_function_low;
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        rvalid_q;
  logic [1:0]  rresp_q;
  logic [31:0] rdata_q;

  // clear on power-on reset or hardware standby
  wire         clear_now   = ~HW_STANDBY;
  wire         aw_take     = AWVALID & ~aw_held & ~bvalid_q;
  wire         w_take      = WVALID & ~w_held & ~bvalid_q;
  wire         wr_go       = aw_held & w_held & ~bvalid_q;
  wire         lo_we       = w_strb[0];
  wire         hi_we       = w_strb[1];
  wire         wr_hmode    = wr_go & (aw_addr == PJM_OFF_HPORT_MODE);
  wire         wr_jdir     = wr_go & (aw_addr == PJM_OFF_J_DIR);
  wire         wr_jfh      = wr_go & (aw_addr == PJM_OFF_J_FUNC_HIGH);
  wire         wr_jfl      = wr_go & (aw_addr == PJM_OFF_J_FUNC_LOW);
  wire         wr_stat     = wr_go & (aw_addr == PJM_OFF_OP_STATUS);
  wire         wr_hit      = wr_hmode | wr_jdir | wr_jfh | wr_jfl | wr_stat;
  wire         ar_take     = ARVALID & ~rvalid_q;
  wire [15:0]  wr_word     = w_data[15:0];
  wire [15:0]  next_jdir   = {hi_we ? wr_word[15:8] : port_j_direction[15:8],
                              lo_we ? wr_word[7:0] : port_j_direction[7:0]};
  wire [15:0]  next_jfh    = {hi_we ? wr_word[15:8] : port_j_function_high[15:8],
                              lo_we ? wr_word[7:0] : port_j_function_high[7:0]}
                             & PJM_JFUNC_MASK;
  wire [15:0]  next_jfl    = {hi_we ? wr_word[15:8] : port_j_function_low[15:8],
                              lo_we ? wr_word[7:0] : port_j_function_low[7:0]}
                             & PJM_JFUNC_MASK;
  wire [5:0]   next_hmode  = lo_we ? wr_word[5:0] : hport_mode;

  // read decode
  wire         rd_hmode    = ARADDR == PJM_OFF_HPORT_MODE;
  wire         rd_jdir     = ARADDR == PJM_OFF_J_DIR;
  wire         rd_jfh      = ARADDR == PJM_OFF_J_FUNC_HIGH;
  wire         rd_jfl      = ARADDR == PJM_OFF_J_FUNC_LOW;
  wire         rd_stat     = ARADDR == PJM_OFF_OP_STATUS;
  wire         rd_hit      = rd_hmode | rd_jdir | rd_jfh | rd_jfl | rd_stat;
  wire [31:0]  next_rdata  = rd_hmode ? {26'h0000000, hport_mode} :
                             rd_jdir  ? {16'h0000, port_j_direction} :
                             rd_jfh   ? {16'h0000, port_j_function_high} :
                             rd_jfl   ? {16'h0000, port_j_function_low} :
                             rd_stat  ? {24'h000000, 2'h0, H_IS_BUS} :
                                        32'h00000000;

  // mode bit registers, power-on or hardware standby clears
  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      hport_mode           <= PJM_HMODE_RESET;
      port_j_direction     <= PJM_JDIR_RESET;
      port_j_function_high <= PJM_JFUNC_RESET;
      port_j_function_low  <= PJM_JFUNC_RESET;
    end
    else if (!clear_now)
    begin
      hport_mode           <= PJM_HMODE_RESET;
      port_j_direction     <= PJM_JDIR_RESET;
      port_j_function_high <= PJM_JFUNC_RESET;
      port_j_function_low  <= PJM_JFUNC_RESET;
    end
    else
    begin
      if (wr_hmode)
        hport_mode <= next_hmode;
      if (wr_jdir)
        port_j_direction <= next_jdir;
      if (wr_jfh)
        port_j_function_high <= next_jfh;
      if (wr_jfl)
        port_j_function_low <= next_jfl;
    end
  end

  // write address and data capture, either order
  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h00000000;
      w_strb  <= 4'h0;
    end
    else
    begin
      if (aw_take)
      begin
        aw_held <= 1'b1;
        aw_addr <= AWADDR;
      end
      else if (wr_go)
        aw_held <= 1'b0;
      if (w_take)
      begin
        w_held <= 1'b1;
        w_data <= WDATA;
        w_strb <= WSTRB;
      end
      else if (wr_go)
        w_held <= 1'b0;
    end
  end

  // write response
  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      bvalid_q <= 1'b0;
      bresp_q  <= PJM_RESP_OKAY;
    end
    else if (wr_go)
    begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_hit ? PJM_RESP_OKAY : PJM_RESP_SLVERR;
    end
    else if (BREADY)
      bvalid_q <= 1'b0;
  end

  // read response
  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      rvalid_q <= 1'b0;
      rresp_q  <= PJM_RESP_OKAY;
      rdata_q  <= 32'h00000000;
    end
    else if (ar_take)
    begin
      rvalid_q <= 1'b1;
      rresp_q  <= rd_hit ? PJM_RESP_OKAY : PJM_RESP_SLVERR;
      rdata_q  <= next_rdata;
    end
    else if (RREADY)
      rvalid_q <= 1'b0;
  end

  // bus handshake outputs
  assign AWREADY = ~aw_held & ~bvalid_q;
  assign WREADY  = ~w_held & ~bvalid_q;
  assign BVALID  = bvalid_q;
  assign BRESP   = bresp_q;
  assign ARREADY = ~rvalid_q;
  assign RVALID  = rvalid_q;
  assign RRESP   = rresp_q;
  assign RDATA   = rdata_q;

  // port-J selects gathered from even bits
  genvar i;
  generate
    for (i = 0; i < 8; i++)
    begin : g_jsel
      assign J_TIMER_SEL[i + 8] = port_j_function_high[2 * i];
      assign J_TIMER_SEL[i]     = port_j_function_low[2 * i];
    end
  endgenerate

  // per-pin port-H muxes
  generate
    for (i = 0; i < 6; i++)
    begin : g_hpin
      pjm_hpin u_hpin
      (
        .op_mode  (OP_MODE),
        .mode_bit (hport_mode[i]),
        .gpio_dir (H_GPIO_DIR[i]),
        .gpio_out (H_GPIO_OUT[i]),
        .bus_oe   (EXT_DATA_OE[i]),
        .bus_out  (EXT_DATA_OUT[i]),
        .is_bus   (H_IS_BUS[i]),
        .pin_out  (H_PIN_OUT[i]),
        .pin_oe   (H_PIN_OE[i])
      );
    end
  endgenerate

  // per-pin port-J muxes
  generate
    for (i = 0; i < 16; i++)
    begin : g_jpin
      pjm_jpin u_jpin
      (
        .mode_bit  (J_TIMER_SEL[i]),
        .dir_bit   (port_j_direction[i]),
        .gpio_out  (J_GPIO_OUT[i]),
        .timer_out (J_TIMER_OUT[i]),
        .pin_out   (J_PIN_OUT[i]),
        .pin_oe    (J_PIN_OE[i])
      );
    end
  endgenerate
endmodule : pjm_top

// ---- rtl/pjm_pkg.sv ----
// Purpose: constants for the port H/J pin function select block
// Assumes: AXI4-Lite register access, 32-bit data, one word per register
// Notes:   offsets are byte addresses
package pjm_pkg;
  localparam int          PJM_ADDR_W          = 8;
  localparam logic [7:0]  PJM_OFF_HPORT_MODE  = 8'h00;
  localparam logic [7:0]  PJM_OFF_J_DIR       = 8'h04;
  localparam logic [7:0]  PJM_OFF_J_FUNC_HIGH = 8'h08;
  localparam logic [7:0]  PJM_OFF_J_FUNC_LOW  = 8'h0C;
  localparam logic [7:0]  PJM_OFF_OP_STATUS   = 8'h10;
  localparam logic [5:0]  PJM_HMODE_RESET     = 6'h00;
  localparam logic [15:0] PJM_JDIR_RESET      = 16'h0000;
  localparam logic [15:0] PJM_JFUNC_RESET     = 16'h0000;
  // mode bits sit at even positions, odd positions read zero
  localparam logic [15:0] PJM_JFUNC_MASK      = 16'h5555;
  localparam logic [1:0]  PJM_RESP_OKAY       = 2'h0;
  localparam logic [1:0]  PJM_RESP_SLVERR     = 2'h2;
  // operating mode encoding on the mode input
  typedef enum logic [1:0] {
    PJM_OP_EXP_ROM_OFF = 2'h0,
    PJM_OP_EXP_ROM_ON  = 2'h1,
    PJM_OP_SINGLE_CHIP = 2'h2
  } pjm_op_t;
endpackage : pjm_pkg

// ---- rtl/pjm_hpin.sv ----
// Purpose: one low port-H pin, general I/O or external data line
// Assumes: bus controller supplies data-line direction
// Notes:   purely combinational
`timescale 1ns/1ps
module pjm_hpin
  import pjm_pkg::*;
(
  // selection
  input  wire logic [1:0] op_mode,
  input  wire logic       mode_bit,
  input  wire logic       gpio_dir,
  input  wire logic       gpio_out,
  input  wire logic       bus_oe,
  input  wire logic       bus_out,
  // pin side
  output logic            is_bus,
  output logic            pin_out,
  output logic            pin_oe
);
  // function choice by operating mode
  assign is_bus  = (op_mode == PJM_OP_EXP_ROM_OFF) |
                   ((op_mode == PJM_OP_EXP_ROM_ON) & mode_bit);
  // bus owns direction when routed to the data bus
  assign pin_oe  = is_bus ? bus_oe : gpio_dir;
  assign pin_out = is_bus ? bus_out : gpio_out;
endmodule : pjm_hpin

// ---- rtl/pjm_jpin.sv ----
// Purpose: one port-J pin, general I/O or timer-unit function
// Assumes: direction bit holds for both functions
// Notes:   any pin with its mode bit and direction bit set drives from the timer
`timescale 1ns/1ps
module pjm_jpin
(
  // selection
  input  wire logic mode_bit,
  input  wire logic dir_bit,
  input  wire logic gpio_out,
  input  wire logic timer_out,
  // pin side
  output logic      pin_out,
  output logic      pin_oe
);
  // direction bit acts in both allowed functions
  assign pin_oe  = dir_bit;
  assign pin_out = mode_bit ? timer_out : gpio_out;
endmodule : pjm_jpin

// ---- tb/pjm_top_chk.sv ----
// Purpose: port-level checks for pjm_top
// Assumes: pin paths combinational, registers behind AXI4-Lite
// Notes:   bound onto every pjm_top instance
`timescale 1ns/1ps
module pjm_top_chk
  import pjm_pkg::*;
(
  // clock, reset and mode
  input wire logic        REF_CLK, RST_B, HW_STANDBY,
  input wire logic [1:0]  OP_MODE,
  // bus handshakes
  input wire logic        AWVALID, AWREADY, WVALID, WREADY, BVALID, ARVALID, ARREADY, RVALID,
  // port H
  input wire logic [5:0]  H_GPIO_DIR, H_GPIO_OUT, EXT_DATA_OE, EXT_DATA_OUT, H_IS_BUS, H_PIN_OUT, H_PIN_OE,
  // port J
  input wire logic [15:0] J_GPIO_OUT, J_TIMER_OUT, J_TIMER_SEL, J_PIN_OUT, J_PIN_OE
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_B);
  // expected pin drive from the selected source
  wire [5:0]  h_oe  = (H_IS_BUS & EXT_DATA_OE) | (~H_IS_BUS & H_GPIO_DIR);
  wire [5:0]  h_out = (H_IS_BUS & EXT_DATA_OUT) | (~H_IS_BUS & H_GPIO_OUT);
  wire [15:0] j_out = (J_TIMER_SEL & J_TIMER_OUT) | (~J_TIMER_SEL & J_GPIO_OUT);
  // timer-selected pins 10 to 15 are left out of the data check
  wire [15:0] j_msk = J_PIN_OE & ~(J_TIMER_SEL & 16'hFC00);
  chk_romoff_bus:
    assert property (OP_MODE == PJM_OP_EXP_ROM_OFF |-> H_IS_BUS == 6'h3F) else $error("data bus not routed");
  chk_single_gpio:
    assert property (OP_MODE == PJM_OP_SINGLE_CHIP |-> H_IS_BUS == 6'h00) else $error("bus routed in single-chip");
  chk_hpin_oe:
    assert property (H_PIN_OE == h_oe) else $error("port H drive enable wrong");
  chk_hpin_out:
    assert property ((H_PIN_OUT & H_PIN_OE) == (h_out & H_PIN_OE)) else $error("port H data wrong");
  chk_jpin_out:
    assert property ((J_PIN_OUT & j_msk) == (j_out & j_msk)) else $error("port J data wrong");
  chk_jdir_hold:
    assert property (!$stable(J_PIN_OE) |-> $rose(BVALID) || $past(HW_STANDBY)) else $error("direction moved");
  chk_jsel_hold:
    assert property (!$stable(J_TIMER_SEL) |-> $rose(BVALID) || $past(HW_STANDBY)) else $error("function moved");
  chk_stby_clear:
    assert property (HW_STANDBY |=> J_PIN_OE == 16'h0000 && J_TIMER_SEL == 16'h0000) else $error("standby no clear");
  chk_wr_answer:
    assert property (AWVALID && AWREADY && WVALID && WREADY |-> ##2 BVALID) else $error("write answer late");
  chk_rd_answer:
    assert property (ARVALID && ARREADY |=> RVALID) else $error("read answer late");
endmodule : pjm_top_chk
bind pjm_top pjm_top_chk pjm_top_chk_i (.*);

// ---- tb/pjm_far_model.sv ----
// Purpose: bus controller and timer unit seen from the pins
// Assumes: both drive every cycle
// Notes:   pattern moves each cycle so a stale route shows
`timescale 1ns/1ps
module pjm_far_model
(
  // clock and reset
  input wire logic   clk, rst_b,
  // bus controller and timer drive
  output logic [5:0]  ext_oe, ext_out,
  output logic [15:0] timer_out
);
  logic [15:0] step;
  // free stepping pattern
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      step <= 16'h0001;
    else
      step <= step + 16'h3B7;
  // bus controller decides data-line direction
  assign ext_oe    = step[5:0];
  assign ext_out   = ~step[11:6];
  // timer drive for the capture/compare pins
  assign timer_out = {step[7:0], ~step[15:8]};
endmodule : pjm_far_model

// ---- tb/tb_top.sv ----
// Purpose: self-checking bench for pjm_top
// Assumes: tasks are entered just after a rising edge
// Notes:   outputs sampled at the falling edge
`timescale 1ns/1ps
module tb_top;
  import pjm_pkg::*;
  logic        REF_CLK, RST_B, HW_STANDBY, AWVALID, WVALID, BREADY, ARVALID, RREADY;
  logic        AWREADY, WREADY, BVALID, ARREADY, RVALID;
  logic [1:0]  OP_MODE, BRESP, RRESP, rs;
  logic [7:0]  AWADDR, ARADDR;
  logic [31:0] WDATA, RDATA, rv;
  logic [3:0]  WSTRB;
  logic [5:0]  H_GPIO_DIR, H_GPIO_OUT, EXT_DATA_OE, EXT_DATA_OUT, H_IS_BUS, H_PIN_OUT, H_PIN_OE, eb;
  logic [15:0] J_GPIO_OUT, J_TIMER_OUT, J_TIMER_SEL, J_PIN_OUT, J_PIN_OE;
  int          n_errors, n_tests;
  pjm_top pjm_top_i (.*);
  pjm_far_model pjm_far_model_i (.clk(REF_CLK), .rst_b(RST_B), .ext_oe(EXT_DATA_OE), .ext_out(EXT_DATA_OUT),
                                 .timer_out(J_TIMER_OUT));
  // clock
  initial
  begin
    REF_CLK = 1'b0;
    forever #50 REF_CLK = ~REF_CLK;
  end
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tk;
    {ta, tw, tk} = 3'b000;
    AWADDR  <= a;
    WDATA   <= d;
    AWVALID <= 1'b1;
    WVALID  <= 1'b1;
    BREADY  <= 1'b1;
    while (!(ta && tw))
    begin
      @(negedge REF_CLK);
      ta = ta | (AWVALID & AWREADY);
      tw = tw | (WVALID & WREADY);
      @(posedge REF_CLK);
      if (ta) AWVALID <= 1'b0;
      if (tw) WVALID <= 1'b0;
    end
    while (!tk)
    begin
      @(negedge REF_CLK);
      tk = BVALID;
      rs = BRESP;
      @(posedge REF_CLK);
    end
    BREADY <= 1'b0;
    // idle edge so a following call never re-raises bready in this step
    @(posedge REF_CLK);
  endtask : wr
  task rd(input logic [7:0] a);
    logic ta, tr;
    {ta, tr} = 2'b00;
    ARADDR  <= a;
    ARVALID <= 1'b1;
    RREADY  <= 1'b1;
    while (!ta)
    begin
      @(negedge REF_CLK);
      // address taken is judged from settled values before the edge
      tr = tr | (ARVALID & ARREADY);
      if (RVALID) {ta, rv, rs} = {1'b1, RDATA, RRESP};
      @(posedge REF_CLK);
      if (tr) ARVALID <= 1'b0;
    end
    RREADY <= 1'b0;
    // idle edge so a following call never re-raises rready in this step
    @(posedge REF_CLK);
  endtask : rd
  task t_reset;
    for (int i = 0; i < 4; i++)
    begin
      rd(8'(4 * i));
      chk("reset value", rv, 32'h0);
    end
    chk("reset oe", 32'(J_PIN_OE), 32'h0);
    chk("reset route", 32'(H_IS_BUS), 32'h0);
    $display("reset test done");
  endtask : t_reset
  task t_hport;
    wr(PJM_OFF_HPORT_MODE, 32'h2A);
    rd(PJM_OFF_HPORT_MODE);
    chk("h mode", rv, 32'h2A);
    for (int m = 0; m < 4; m++)
    begin
      OP_MODE <= 2'(m);
      eb = (m == 0) ? 6'h3F : (m == 1) ? 6'h2A : 6'h00;
      @(negedge REF_CLK);
      chk("h route", 32'(H_IS_BUS), 32'(eb));
      chk("h oe", 32'(H_PIN_OE), 32'((eb & EXT_DATA_OE) | (~eb & H_GPIO_DIR)));
      chk("h out", 32'(H_PIN_OUT), 32'((eb & EXT_DATA_OUT) | (~eb & H_GPIO_OUT)));
      @(posedge REF_CLK);
    end
    OP_MODE <= PJM_OP_EXP_ROM_ON;
    rd(PJM_OFF_OP_STATUS);
    chk("h status", rv, 32'h2A);
    $display("port H test done");
  endtask : t_hport
  task t_jport;
    wr(PJM_OFF_J_FUNC_HIGH, 32'hFFFF);
    rd(PJM_OFF_J_FUNC_HIGH);
    chk("reserved bits", rv, 32'h5555);
    wr(PJM_OFF_J_FUNC_LOW, 32'h5555);
    wr(PJM_OFF_J_DIR, 32'hFFFF);
    @(negedge REF_CLK);
    chk("all timer", 32'(J_TIMER_SEL), 32'hFFFF);
    chk("all out", 32'(J_PIN_OE), 32'hFFFF);
    @(posedge REF_CLK);
    wr(PJM_OFF_J_FUNC_HIGH, 32'h0004);
    wr(PJM_OFF_J_FUNC_LOW, 32'h4001);
    wr(PJM_OFF_J_DIR, 32'h0B8F);
    @(negedge REF_CLK);
    // high bit 2 selects pin 9, low bits 0 and 14 select pins 0 and 7
    chk("mixed sel", 32'(J_TIMER_SEL), 32'h0281);
    chk("mixed oe", 32'(J_PIN_OE), 32'h0B8F);
    chk("mixed out", 32'(J_PIN_OUT & 16'h0B8F),
        32'(((J_TIMER_OUT & 16'h0281) | (J_GPIO_OUT & 16'hFD7E)) & 16'h0B8F));
    @(posedge REF_CLK);
    $display("port J test done");
  endtask : t_jport
  task t_stby;
    rd(8'h20);
    chk("unmapped resp", 32'(rs), 32'(PJM_RESP_SLVERR));
    chk("unmapped data", rv, 32'h0);
    HW_STANDBY <= 1'b1;
    wr(PJM_OFF_J_DIR, 32'hFFFF);
    chk("standby write", 32'(rs), 32'(PJM_RESP_OKAY));
    HW_STANDBY <= 1'b0;
    rd(PJM_OFF_J_DIR);
    chk("standby dir", rv, 32'h0);
    rd(PJM_OFF_J_FUNC_LOW);
    chk("standby func", rv, 32'h0);
    rd(PJM_OFF_J_FUNC_HIGH);
    chk("standby func high", rv, 32'h0);
    $display("standby test done");
  endtask : t_stby
  task t_mid_reset;
    wr(PJM_OFF_J_DIR, 32'hFFFF);
    wr(PJM_OFF_J_FUNC_HIGH, 32'h5555);
    wr(PJM_OFF_HPORT_MODE, 32'h3F);
    RST_B <= 1'b0;
    repeat (2) @(posedge REF_CLK);
    RST_B <= 1'b1;
    @(posedge REF_CLK);
    @(negedge REF_CLK);
    chk("rerun oe", 32'(J_PIN_OE), 32'h0);
    chk("rerun sel", 32'(J_TIMER_SEL), 32'h0);
    chk("rerun route", 32'(H_IS_BUS), 32'h0);
    @(posedge REF_CLK);
    rd(PJM_OFF_J_DIR);
    chk("rerun dir", rv, 32'h0);
    $display("mid-run reset test done");
  endtask : t_mid_reset
  task end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test
  // watchdog
  initial
  begin
    #2000000;
    n_errors++;
    end_of_test;
  end
  // main sequence
  initial
  begin
    {RST_B, HW_STANDBY, AWVALID, WVALID, BREADY, ARVALID, RREADY} = 7'h0;
    {AWADDR, ARADDR, WDATA, WSTRB} = {16'h0, 32'h0, 4'hF};
    {OP_MODE, H_GPIO_DIR, H_GPIO_OUT, J_GPIO_OUT} = {PJM_OP_EXP_ROM_ON, 6'h0F, 6'h33, 16'hA5C3};
    repeat (5) @(posedge REF_CLK);
    RST_B <= 1'b1;
    @(posedge REF_CLK);
    t_reset;
    t_hport;
    t_jport;
    t_stby;
    t_mid_reset;
    end_of_test;
  end
endmodule : tb_top
